// *** sei_defines.svh ***
// Purpose: Shared constants of the serial EEPROM slave
// Assumes: 4 Kbit organisation, 512 bytes, 16-byte page
// Notes: Timing counts derive from the 20 MHz system clock
`ifndef SEI_DEFINES_SVH
`define SEI_DEFINES_SVH

`define SEI_ADDR_W 9
`define SEI_MEM_BYTES 512
`define SEI_PAGE_BYTES 16
`define SEI_PAGE_W 4
`define SEI_BYTE_BITS 4'h8
`define SEI_CIDX_W 5
`define SEI_CIDX_END 5'h10
`define SEI_CLK_HZ 20000000
`define SEI_T_WR_MS 10
`define SEI_WR_CYCLES (`SEI_T_WR_MS * (`SEI_CLK_HZ / 1000))
`define SEI_TMR_W 18
// Sync and exit clocks taken off the timer so STOP to ready stays in bound
`define SEI_WR_MARGIN 8
// Device-type code, value arbitrary
`define SEI_DEV_TYPE 4'h5
`define SEI_SDA_LOW 1'b0
`define SEI_SYNC_RST 3'h7

`endif

// *** sei_pkg.sv ***
// Purpose: Types of the serial EEPROM slave
// Assumes: Constants come from the defines header
// Notes: Sync, timer and core modules each keep their state in one packed struct, the core's array aside
`include "sei_defines.svh"

package sei_pkg;

    typedef enum logic [3:0] {
        S_IDLE, S_DEV, S_WORD, S_WDATA, S_ACK, S_RD, S_RACK, S_WAIT, S_PROG
    } sei_state_type;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] wp_s;
        logic scl_f;
        logic sda_f;
        logic wp_f;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } sei_sync_type;

    typedef struct packed {
        logic busy;
        logic [`SEI_TMR_W-1:0] cnt;
    } sei_tmr_type;

    typedef struct packed {
        sei_state_type st;
        sei_state_type ack_st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [`SEI_ADDR_W-1:0] addr;
        logic oe;
        logic rack;
        logic got_data;
        logic [`SEI_PAGE_BYTES-1:0] bvalid;
        logic [`SEI_PAGE_BYTES-1:0][7:0] pbuf;
        logic [`SEI_CIDX_W-1:0] cidx;
    } sei_core_type;

endpackage : sei_pkg

// *** sei_ev_if.sv ***
// Purpose: Filtered bus levels and bus events between sampler and core
// Assumes: All signals are single-cycle flops on clk_i
// Notes: Events are one-cycle pulses
`timescale 1ns/1ps

interface sei_ev_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic wp;
    modport src (output scl_rise, scl_fall, start, stop, sda, wp);
    modport snk (input scl_rise, scl_fall, start, stop, sda, wp);
endinterface : sei_ev_if

// *** sei_pin_sync.sv ***
// Purpose: Samples the bus pins and the protect pin, finds edges and conditions
// Assumes: Pins are asynchronous to clk_i
// Notes: A level change counts once the second and third stages agree
`timescale 1ns/1ps
`include "sei_defines.svh"

module sei_pin_sync (
    input logic clk_i,
    input logic rst_i,
    input logic scl_i,
    input logic sda_i,
    input logic wp_i,
    sei_ev_if.src ev
);

    localparam sei_pkg::sei_sync_type RST_VAL = '{
        scl_s: `SEI_SYNC_RST, sda_s: `SEI_SYNC_RST, wp_s: 3'h0,
        scl_f: 1'b1, sda_f: 1'b1, wp_f: 1'b0,
        scl_rise: 1'b0, scl_fall: 1'b0, start: 1'b0, stop: 1'b0};

    sei_pkg::sei_sync_type s_r;
    sei_pkg::sei_sync_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_s = {s_r.scl_s[1:0], scl_i};
        s_nxt.sda_s = {s_r.sda_s[1:0], sda_i};
        s_nxt.wp_s = {s_r.wp_s[1:0], wp_i};
        // Agreement of two stages rejects a single sampled glitch
        if (s_r.scl_s[1] == s_r.scl_s[2]) begin
            s_nxt.scl_f = s_r.scl_s[2];
        end
        if (s_r.sda_s[1] == s_r.sda_s[2]) begin
            s_nxt.sda_f = s_r.sda_s[2];
        end
        if (s_r.wp_s[1] == s_r.wp_s[2]) begin
            s_nxt.wp_f = s_r.wp_s[2];
        end
        s_nxt.scl_rise = !s_r.scl_f && s_nxt.scl_f;
        s_nxt.scl_fall = s_r.scl_f && !s_nxt.scl_f;
        s_nxt.start = s_r.scl_f && s_nxt.scl_f && s_r.sda_f && !s_nxt.sda_f;
        s_nxt.stop = s_r.scl_f && s_nxt.scl_f && !s_r.sda_f && s_nxt.sda_f;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= RST_VAL;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ev.scl_rise = s_r.scl_rise;
    assign ev.scl_fall = s_r.scl_fall;
    assign ev.start = s_r.start;
    assign ev.stop = s_r.stop;
    assign ev.sda = s_r.sda_f;
    assign ev.wp = s_r.wp_f;

endmodule : sei_pin_sync

// *** sei_wr_timer.sv ***
// Purpose: Self-timed programming interval
// Assumes: start_i is a one-cycle pulse while idle
// Notes: busy_o stays high one clock more than WR_CYCLES less the sync margin
`timescale 1ns/1ps
`include "sei_defines.svh"

module sei_wr_timer #(
    parameter int WR_CYCLES = `SEI_WR_CYCLES
) (
    input logic clk_i,
    input logic rst_i,
    input logic start_i,
    output logic busy_o
);

    localparam logic [`SEI_TMR_W-1:0] LAST = `SEI_TMR_W'(WR_CYCLES - `SEI_WR_MARGIN);

    sei_pkg::sei_tmr_type t_r;
    sei_pkg::sei_tmr_type t_nxt;

    always_comb begin
        t_nxt = t_r;
        if (start_i) begin
            t_nxt.busy = 1'b1;
            t_nxt.cnt = LAST;
        end else if (t_r.busy) begin
            if (t_r.cnt == '0) begin
                t_nxt.busy = 1'b0;
            end else begin
                t_nxt.cnt = t_r.cnt - `SEI_TMR_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign busy_o = t_r.busy;

    property p_tmr_load;
        @(posedge clk_i) disable iff (rst_i)
        start_i |=> t_r.busy && t_r.cnt == LAST;
    endproperty
    a_tmr_load: assert property (p_tmr_load) else $error("Timer not loaded");

    property p_tmr_end;
        @(posedge clk_i) disable iff (rst_i)
        t_r.busy && t_r.cnt == '0 && !start_i |=> !t_r.busy ##1 !t_r.busy || start_i;
    endproperty
    a_tmr_end: assert property (p_tmr_end) else $error("Timer overran");

endmodule : sei_wr_timer

// *** sei_eeprom_slave.sv ***
// Purpose: Two-wire slave of a 512-byte EEPROM with page buffer and write timer
// Assumes: Master owns the serial clock; pins are asynchronous to clk_i
// Notes: The array is a register file; programming copies the page buffer into it
`timescale 1ns/1ps
`include "sei_defines.svh"

// How it works
// - Byte write: START, write slave address, acknowledged, then byte address loads pointer
// - Data byte acknowledged; following STOP starts the programming cycle
// - During programming every bus request is ignored, nothing driven
// - Page buffer holds sixteen bytes, all programmed in one cycle
// - Each page data byte is acknowledged and bumps only the low address bits
// - Beyond sixteen bytes the low address wraps and overwrites earlier bytes
// - STOP after page data commits all received bytes in one cycle
// - Polling address is not acknowledged while programming runs
// - Polling address is acknowledged once programming has finished
// - Write protect high: addresses acknowledged, data refused, array untouched
// - Reads are addressed like writes with the direction bit set
// - Address counter holds last accessed address plus one
// - Counter at the top address wraps to zero
// - Immediate read: acknowledge, one byte out, master nacks then STOP
// - Selective read: dummy write of address, repeated START, read address
// - Each master acknowledge fetches the byte at the following address
// - Missing master acknowledge ends the read; device releases data
// - Reads increment every address bit, streaming the whole array
// - Slave byte: type code, three select or upper address bits, direction
// - Uncompared select bit supplies the upper array address bit
// - Acknowledge is data held low during the ninth clock
// - Programming lasts at most ten milliseconds, bus disabled throughout
module sei_eeprom_slave #(
    parameter int WR_CYCLES = `SEI_WR_CYCLES
) (
    input logic clk_i,
    input logic rst_i,
    input logic scl_i,
    input logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input logic wp_i,
    input logic [1:0] chip_select_straps_i,
    output logic write_busy_o
);

    localparam sei_pkg::sei_core_type RST_VAL = '{
        st: sei_pkg::S_IDLE, ack_st: sei_pkg::S_IDLE, bitcnt: 4'h0, shreg: 8'h00,
        addr: '0, oe: 1'b0, rack: 1'b0, got_data: 1'b0, bvalid: '0, pbuf: '0,
        cidx: '0};

    sei_ev_if ev ();

    sei_pkg::sei_core_type r;
    sei_pkg::sei_core_type n;
    logic [7:0] mem [0:`SEI_MEM_BYTES-1];
    logic mem_we;
    logic [`SEI_ADDR_W-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] rd_byte;
    logic tmr_start;
    logic tmr_busy;
    logic rx_done;
    logic dev_hit;

    // Type code, two strapped select bits, one upper address bit, direction
    function automatic logic sei_match(input logic [7:0] b, input logic [1:0] straps);
        sei_match = (b[7:4] == `SEI_DEV_TYPE) && (b[3:2] == straps);
    endfunction : sei_match

    function automatic logic sei_is_rx(input sei_pkg::sei_state_type s);
        sei_is_rx = (s == sei_pkg::S_DEV) || (s == sei_pkg::S_WORD) ||
                    (s == sei_pkg::S_WDATA);
    endfunction : sei_is_rx

    sei_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .wp_i(wp_i),
        .ev(ev)
    );

    sei_wr_timer #(
        .WR_CYCLES(WR_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(tmr_start),
        .busy_o(tmr_busy)
    );

    assign rd_byte = mem[r.addr];
    assign rx_done = ev.scl_fall && r.bitcnt == `SEI_BYTE_BITS && sei_is_rx(r.st);
    assign dev_hit = sei_match(r.shreg, chip_select_straps_i);

    always_comb begin
        n = r;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = 8'h00;
        tmr_start = 1'b0;
        if (r.st == sei_pkg::S_PROG) begin
            // Bus events are not looked at here at all
            n.oe = 1'b0;
            if (r.cidx < `SEI_CIDX_END) begin
                // One buffered byte per clock; the interval hides the copy
                mem_we = r.bvalid[r.cidx[`SEI_PAGE_W-1:0]];
                mem_wa = {r.addr[`SEI_ADDR_W-1:`SEI_PAGE_W], r.cidx[`SEI_PAGE_W-1:0]};
                mem_wd = r.pbuf[r.cidx[`SEI_PAGE_W-1:0]];
                n.cidx = r.cidx + `SEI_CIDX_W'(1);
            end else if (!tmr_busy) begin
                n.st = sei_pkg::S_IDLE;
                n.bvalid = '0;
            end
        end else if (ev.stop || ev.start) begin
            n.oe = 1'b0;
            n.bitcnt = 4'h0;
            n.st = ev.stop ? sei_pkg::S_IDLE : sei_pkg::S_DEV;
            if (r.got_data) begin
                // Only whole accepted data bytes reach the array
                n.st = sei_pkg::S_PROG;
                n.cidx = '0;
                n.got_data = 1'b0;
                tmr_start = 1'b1;
            end
        end else begin
            case (r.st)
                sei_pkg::S_DEV, sei_pkg::S_WORD, sei_pkg::S_WDATA: begin
                    if (ev.scl_rise) begin
                        n.shreg = {r.shreg[6:0], ev.sda};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (rx_done) begin
                        n.bitcnt = 4'h0;
                        n.st = sei_pkg::S_ACK;
                        n.oe = 1'b1;
                        if (r.st == sei_pkg::S_DEV) begin
                            if (!dev_hit) begin
                                n.st = sei_pkg::S_WAIT;
                                n.oe = 1'b0;
                            end else begin
                                // A foreign address must not move our pointer
                                n.addr[`SEI_ADDR_W-1] = r.shreg[1];
                            end
                            // Direction bit chooses the path after the ack
                            n.ack_st = r.shreg[0] ? sei_pkg::S_RD : sei_pkg::S_WORD;
                        end else if (r.st == sei_pkg::S_WORD) begin
                            n.addr[7:0] = r.shreg;
                            n.ack_st = sei_pkg::S_WDATA;
                        end else if (ev.wp) begin
                            n.st = sei_pkg::S_WAIT;
                            n.oe = 1'b0;
                        end else begin
                            n.pbuf[r.addr[`SEI_PAGE_W-1:0]] = r.shreg;
                            n.bvalid[r.addr[`SEI_PAGE_W-1:0]] = 1'b1;
                            n.addr[`SEI_PAGE_W-1:0] = r.addr[`SEI_PAGE_W-1:0] +
                                                       `SEI_PAGE_W'(1);
                            n.got_data = 1'b1;
                            n.ack_st = sei_pkg::S_WDATA;
                        end
                    end
                end
                sei_pkg::S_ACK: begin
                    if (ev.scl_fall) begin
                        n.oe = 1'b0;
                        n.st = r.ack_st;
                        n.bitcnt = 4'h0;
                        if (r.ack_st == sei_pkg::S_RD) begin
                            n.shreg = rd_byte;
                            n.addr = r.addr + `SEI_ADDR_W'(1);
                            n.oe = !rd_byte[7];
                            n.bitcnt = 4'h1;
                        end
                    end
                end
                sei_pkg::S_RD: begin
                    if (ev.scl_fall) begin
                        if (r.bitcnt == `SEI_BYTE_BITS) begin
                            n.oe = 1'b0;
                            n.st = sei_pkg::S_RACK;
                        end else begin
                            n.shreg = {r.shreg[6:0], 1'b0};
                            n.oe = !r.shreg[6];
                            n.bitcnt = r.bitcnt + 4'h1;
                        end
                    end
                end
                sei_pkg::S_RACK: begin
                    if (ev.scl_rise) begin
                        n.rack = !ev.sda;
                    end else if (ev.scl_fall) begin
                        if (r.rack) begin
                            n.st = sei_pkg::S_RD;
                            n.shreg = rd_byte;
                            // Full-width carry wraps the top address to zero
                            n.addr = r.addr + `SEI_ADDR_W'(1);
                            n.oe = !rd_byte[7];
                            n.bitcnt = 4'h1;
                        end else begin
                            n.st = sei_pkg::S_WAIT;
                        end
                    end
                end
                sei_pkg::S_IDLE, sei_pkg::S_WAIT: begin
                    n.oe = 1'b0;
                end
                default: begin
                    n = RST_VAL;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= RST_VAL;
        end else begin
            r <= n;
        end
    end

    // Array keeps contents over reset, like the nonvolatile cells it models
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign sda_o = `SEI_SDA_LOW;
    assign sda_oe_o = r.oe;
    assign write_busy_o = (r.st == sei_pkg::S_PROG);

    sequence s_dev_match;
        rx_done && r.st == sei_pkg::S_DEV && dev_hit;
    endsequence

    sequence s_ack_held;
        r.oe && r.st == sei_pkg::S_ACK;
    endsequence

    property p_dev_ack;
        @(posedge clk_i) disable iff (rst_i)
        s_dev_match |=> s_ack_held;
    endproperty
    a_dev_ack: assert property (p_dev_ack) else $error("Own address not acked");

    property p_prog_quiet;
        @(posedge clk_i) disable iff (rst_i)
        r.st == sei_pkg::S_PROG |-> !r.oe;
    endproperty
    a_prog_quiet: assert property (p_prog_quiet) else $error("Drove bus while busy");

    property p_prog_hold;
        @(posedge clk_i) disable iff (rst_i)
        r.st == sei_pkg::S_PROG && tmr_busy |=> r.st == sei_pkg::S_PROG;
    endproperty
    a_prog_hold: assert property (p_prog_hold) else $error("Left busy state early");

    property p_stop_launch;
        @(posedge clk_i) disable iff (rst_i)
        ev.stop && r.got_data && r.st != sei_pkg::S_PROG |=>
            r.st == sei_pkg::S_PROG && tmr_busy;
    endproperty
    a_stop_launch: assert property (p_stop_launch) else $error("No programming");

    property p_wp_nack;
        @(posedge clk_i) disable iff (rst_i)
        rx_done && r.st == sei_pkg::S_WDATA && ev.wp |=>
            r.st == sei_pkg::S_WAIT && !r.oe && r.bvalid == $past(r.bvalid);
    endproperty
    a_wp_nack: assert property (p_wp_nack) else $error("Protected data taken");

    property p_page_inc;
        @(posedge clk_i) disable iff (rst_i)
        rx_done && r.st == sei_pkg::S_WDATA && !ev.wp |=>
            r.addr[8:4] == $past(r.addr[8:4]) && r.addr[3:0] == $past(r.addr[3:0]) + 4'h1;
    endproperty
    a_page_inc: assert property (p_page_inc) else $error("Bad page increment");

    property p_rd_inc;
        @(posedge clk_i) disable iff (rst_i)
        r.st == sei_pkg::S_RACK && ev.scl_fall && r.rack && !ev.start && !ev.stop |=>
            r.addr == $past(r.addr) + 9'h001 && r.shreg == $past(rd_byte);
    endproperty
    a_rd_inc: assert property (p_rd_inc) else $error("Bad read increment");

    property p_rd_end;
        @(posedge clk_i) disable iff (rst_i)
        r.st == sei_pkg::S_RACK && ev.scl_fall && !r.rack && !ev.start && !ev.stop |=>
            r.st == sei_pkg::S_WAIT && !r.oe;
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("Read did not end");

    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
        ev.start && r.st != sei_pkg::S_PROG && !r.got_data |=>
            r.st == sei_pkg::S_DEV && r.bitcnt == 4'h0 && !r.oe;
    endproperty
    a_abort: assert property (p_abort) else $error("Start did not restart");

    property p_word_load;
        @(posedge clk_i) disable iff (rst_i)
        rx_done && r.st == sei_pkg::S_WORD |=>
            r.addr[7:0] == $past(r.shreg) && r.oe && r.st == sei_pkg::S_ACK;
    endproperty
    a_word_load: assert property (p_word_load) else $error("Byte address not taken");

    property p_dev_miss;
        @(posedge clk_i) disable iff (rst_i)
        rx_done && r.st == sei_pkg::S_DEV && !dev_hit |=>
            r.st == sei_pkg::S_WAIT && !r.oe && r.addr == $past(r.addr);
    endproperty
    a_dev_miss: assert property (p_dev_miss) else $error("Foreign address taken");

    property p_ack_end;
        @(posedge clk_i) disable iff (rst_i)
        r.st == sei_pkg::S_ACK && ev.scl_fall && r.ack_st != sei_pkg::S_RD |=>
            !r.oe && r.st == $past(r.ack_st);
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("Ack not released");

    property p_rd_first;
        @(posedge clk_i) disable iff (rst_i)
        r.st == sei_pkg::S_ACK && ev.scl_fall && r.ack_st == sei_pkg::S_RD |=>
            r.st == sei_pkg::S_RD && r.shreg == $past(rd_byte) &&
            r.addr == $past(r.addr) + 9'h001;
    endproperty
    a_rd_first: assert property (p_rd_first) else $error("First read byte wrong");

    property p_rd_turn;
        @(posedge clk_i) disable iff (rst_i)
        r.st == sei_pkg::S_RD && ev.scl_fall && r.bitcnt == `SEI_BYTE_BITS |=>
            r.st == sei_pkg::S_RACK && !r.oe;
    endproperty
    a_rd_turn: assert property (p_rd_turn) else $error("Data not released");

    property p_prog_exit;
        @(posedge clk_i) disable iff (rst_i)
        r.st == sei_pkg::S_PROG && !tmr_busy && r.cidx == `SEI_CIDX_END |=>
            r.st == sei_pkg::S_IDLE && r.bvalid == '0;
    endproperty
    a_prog_exit: assert property (p_prog_exit) else $error("Busy not left");

endmodule : sei_eeprom_slave

// *** sei_bus_master.sv ***
// Purpose: Behavioural two-wire bus master that drives the EEPROM slave
// Assumes: The data line has a pull-up; each party only pulls it low
// Notes: A bit is eight clocks, six low and two high; the slave answers five after a fall
`timescale 1ns/1ps

module sei_bus_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic qtr;
        repeat (4) @(posedge clk_i);
    endtask : qtr

    // Also serves as repeated start: data released while the clock is low
    task automatic start;
        qtr();
        sda_oe_o <= 1'b0;
        qtr();
        scl_o <= 1'b1;
        qtr();
        sda_oe_o <= 1'b1;
        qtr();
        scl_o <= 1'b0;
    endtask : start

    task automatic stop;
        qtr();
        sda_oe_o <= 1'b1;
        qtr();
        scl_o <= 1'b1;
        qtr();
        sda_oe_o <= 1'b0;
        qtr();
    endtask : stop

    // Long low phase: the slave's drive must settle before the clock rises
    task automatic bit_xfer(input logic b, output logic r);
        repeat (2) @(posedge clk_i);
        sda_oe_o <= ~b;
        repeat (4) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        r = sda_i;
        scl_o <= 1'b0;
    endtask : bit_xfer

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(~more, r);
    endtask : rd_byte
endmodule : sei_bus_master

// *** tb_serial_eeprom_i2c_slave_access.sv ***
// Purpose: Self-checking bench of the EEPROM slave
// Assumes: Short write timer so that polling sees both refusal and acceptance
// Notes: Array content is unknown until written, so reads only visit written places
`timescale 1ns/1ps
`include "sei_defines.svh"

module tb_serial_eeprom_i2c_slave_access;
    localparam int WR_N = 400;
    localparam int CYC_MAX = 60000;
    localparam logic [1:0] STRAPS = 2'h2;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp_r = 1'b0;
    logic scl, m_oe, dev_sda, dev_oe, busy, sda_w;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int busy_len = 0;
    logic a1, a2, a3;
    logic [7:0] rd;
    logic [7:0] pg [$];
    logic [7:0] ex [$];
    // Rows: address and byte; each odd row sits at the next address of the row before
    logic [8:0] row_addr [4] = '{9'h0ff, 9'h100, 9'h1ff, 9'h000};
    logic [7:0] row_data [4] = '{8'h3c, 8'hc3, 8'h81, 8'h7e};

    assign sda_w = ~m_oe & (~dev_oe | dev_sda);

    sei_eeprom_slave #(.WR_CYCLES(WR_N)) sei_eeprom_slave_i (.clk_i(clk_i), .rst_i(rst_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(dev_sda), .sda_oe_o(dev_oe), .wp_i(wp_r),
        .chip_select_straps_i(STRAPS), .write_busy_o(busy));
    sei_bus_master sei_bus_master_i (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (busy === 1'b1) begin
            busy_len <= busy_len + 1;
            chk1("oe while busy", 1'b0, dev_oe);
        end
        if (cyc == CYC_MAX) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic chk1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    function automatic logic [7:0] sla(input logic a8, input logic rdir);
        return {`SEI_DEV_TYPE, STRAPS, a8, rdir};
    endfunction : sla

    task automatic addr_phase(input logic [8:0] a);
        busy_len = 0;
        sei_bus_master_i.start();
        sei_bus_master_i.wr_byte(sla(a[8], 1'b0), a1);
        chk1("slave ack", 1'b1, a1);
        sei_bus_master_i.wr_byte(a[7:0], a2);
        chk1("address ack", 1'b1, a2);
    endtask : addr_phase

    task automatic wr_seq(input logic [8:0] a, input logic [7:0] d [$]);
        addr_phase(a);
        foreach (d[k]) begin
            sei_bus_master_i.wr_byte(d[k], a3);
            chk1("data ack", ~wp_r, a3);
        end
        sei_bus_master_i.stop();
        repeat (4) @(posedge clk_i);
        chk1("busy after stop", ~wp_r, busy);
    endtask : wr_seq

    // Polls right after the stop; refusal is expected only if a write was started
    task automatic poll(input logic exp_busy);
        int nacks;
        nacks = 0;
        a1 = 1'b0;
        while (a1 !== 1'b1 && nacks < 20) begin
            sei_bus_master_i.start();
            sei_bus_master_i.wr_byte(sla(1'b0, 1'b0), a1);
            if (a1 !== 1'b1) nacks++;
        end
        sei_bus_master_i.stop();
        chk1("poll refused", exp_busy, nacks > 0);
        chk1("poll acked", 1'b1, a1);
        chk1("busy length", 1'b1, exp_busy ? busy_len > 0 && busy_len <= WR_N : busy_len == 0);
    endtask : poll

    task automatic rd_seq(input logic sel, input logic [8:0] a, input logic [7:0] e [$]);
        if (sel) addr_phase(a);
        sei_bus_master_i.start();
        sei_bus_master_i.wr_byte(sla(a[8], 1'b1), a1);
        chk1("read slave ack", 1'b1, a1);
        foreach (e[k]) begin
            sei_bus_master_i.rd_byte(k < e.size() - 1, rd);
            chk8("read byte", e[k], rd);
        end
        sei_bus_master_i.stop();
        repeat (8) @(posedge clk_i);
        chk1("data released", 1'b0, dev_oe);
    endtask : rd_seq

    initial begin
        repeat (3) @(posedge clk_i);
        chk1("oe in reset", 1'b0, dev_oe);
        chk1("busy in reset", 1'b0, busy);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        foreach (row_addr[i]) begin
            wr_seq(row_addr[i], {row_data[i]});
            poll(1'b1);
        end
        for (int i = 0; i < 4; i += 2) begin
            rd_seq(1'b1, row_addr[i], {row_data[i]});
            rd_seq(1'b0, row_addr[i + 1], {row_data[i + 1]});
        end
        rd_seq(1'b1, 9'h1ff, {row_data[2], row_data[3]});
        rd_seq(1'b1, 9'h0ff, {row_data[0], row_data[1]});
        // Eighteen bytes from low address e: the last two land on e and f again
        for (int k = 0; k < 18; k++) pg.push_back(8'h40 + 8'(k));
        wr_seq(9'h13e, pg);
        poll(1'b1);
        for (int j = 0; j < 16; j++) ex.push_back(8'h40 + 8'(((j + 2) % 16 < 2) ? (j + 2) % 16 + 16 : (j + 2) % 16));
        rd_seq(1'b1, 9'h130, ex);
        wp_r <= 1'b1;
        repeat (8) @(posedge clk_i);
        wr_seq(9'h0ff, {8'h55, 8'haa});
        poll(1'b0);
        wp_r <= 1'b0;
        rd_seq(1'b1, 9'h0ff, {row_data[0]});
        addr_phase(9'h100);
        for (int k = 0; k < 4; k++) sei_bus_master_i.bit_xfer(k[0], a3);
        sei_bus_master_i.stop();
        poll(1'b0);
        rd_seq(1'b1, 9'h100, {row_data[1]});
        sei_bus_master_i.start();
        sei_bus_master_i.wr_byte({`SEI_DEV_TYPE, ~STRAPS, 2'h0}, a1);
        chk1("straps mismatch ack", 1'b0, a1);
        sei_bus_master_i.start();
        sei_bus_master_i.wr_byte({~`SEI_DEV_TYPE, STRAPS, 2'h0}, a1);
        chk1("type mismatch ack", 1'b0, a1);
        sei_bus_master_i.stop();
        end_sim();
    end
endmodule : tb_serial_eeprom_i2c_slave_access
